// >>> verilog/spd_top.sv
/*
 * Serial port datapath: transmit buffer and shift register, receive
 * frame recovery with 16x/8x oversampling and three-sample voting, a
 * two-entry receive fifo with per-frame error flags, and an APB slave.
 * Assumes rxd_in is already synchronous to mclk and that the sample
 * tick divisor in the baud register is set by software.
 */
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - enabled transmitter drives the serial output pin.
// - writing a character starts transmission once the shift register empties.
// - shift register loads when idle or right after the last stop bit.
// - transmit-complete sets when frame is out and buffer empty.
// - upper data bits beyond character size are dropped on transmit.
// - transmitter disable waits until buffer and shift register are empty.
// - enabled receiver takes serial input pin as its data.
// - bits after start are sampled up to the first stop bit.
// - first stop bit moves frame to receive buffer, sets complete flag.
// - unused upper bits of received data read as zero.
// - error flags travel with their frame; reading data pops the fifo.
// - parity mismatch sets the parity-error flag.
// - receiver disable flushes buffer and drops the frame in progress.
// - oversample sixteen times normally, eight times in double speed.
// - falling edge starts detection; vote samples 8-10 or 4-6.
// - data, parity and first stop bit decided by majority of three.
// - stop bit sampled low sets the frame-error flag.
// - new start edge accepted after stop vote; later in double speed.
// - frame is start, data lsb first, optional parity, stop bits.
// - even parity bit is xor of data; odd is its inverse.
module spd_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial pins
    input  wire logic        rxd_in,
    output logic             txd_out,
    output logic             txd_oe
);

    typedef struct packed {
        // control
        logic                rx_en;
        logic                tx_en;
        logic                dbl;
        logic [2:0]          csize;
        logic [1:0]          pmode;
        logic                stop2;
        logic                tx9;
        logic [11:0]         baud;
        logic [11:0]         bcnt;
        // bus
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
        logic                popok;
        // transmitter
        logic [8:0]          tbuf;
        logic                tbuf_v;
        logic [12:0]         tsh;
        logic [3:0]          tbits;
        logic [4:0]          tsmp;
        logic                tbusy;
        logic                tx_on;
        logic                txc;
        logic                txd;
        // receiver
        spd_pkg::spd_rx_e    rstate;
        logic [4:0]          rsmp;
        logic [3:0]          rbit;
        logic [8:0]          rsh;
        logic                rpar;
        logic [1:0]          votes;
        logic                rlast;
        logic [1:0][11:0]    fifo;
        logic [1:0]          fcnt;
        logic                frd;
        logic                ovf_pend;
    } spd_state_s;

    spd_state_s st_q;
    spd_state_s st_d;

    logic tx_end_ev;
    logic rx_push_ev;
    logic rx_reject_ev;
    logic rx_frame_error_flag_ev;

    function automatic logic [8:0] spd_mask(input logic [3:0] n);
        spd_mask = 9'h1FF >> (spd_pkg::CHAR_MAX - n);
    endfunction : spd_mask

    function automatic logic spd_maj(input logic [2:0] s);
        spd_maj = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : spd_maj

    always_comb begin
        logic [3:0]  nd;
        logic        par_on;
        logic [4:0]  spb;
        logic [4:0]  vmid;
        logic [4:0]  rs;
        logic        tick;
        logic        acc;
        logic        commit;
        logic        clr_txc;
        logic [11:0] head;
        logic [12:0] frame;
        logic        v;
        logic [3:0]  stop_i;
        logic [1:0]  fcnt_p;
        logic        frd_p;
        logic        parity_error_flag;
        nd = 4'h0;
        par_on = 1'b0;
        spb = 5'h00;
        vmid = 5'h00;
        rs = 5'h00;
        tick = 1'b0;
        acc = 1'b0;
        commit = 1'b0;
        clr_txc = 1'b0;
        head = 12'h000;
        frame = 13'h1FFF;
        v = 1'b0;
        stop_i = 4'h0;
        fcnt_p = 2'h0;
        frd_p = 1'b0;
        parity_error_flag = 1'b0;
        st_d = st_q;
        tx_end_ev = 1'b0;
        rx_push_ev = 1'b0;
        rx_reject_ev = 1'b0;
        rx_frame_error_flag_ev = 1'b0;

        nd = (st_q.csize > spd_pkg::CSZ_MAX) ? spd_pkg::CHAR_MAX
                                             : {1'b0, st_q.csize} + spd_pkg::CHAR_MIN;
        par_on = st_q.pmode[1];
        // samples per bit and voting centre
        spb  = st_q.dbl ? spd_pkg::SPB_DOUBLE : spd_pkg::SPB_NORMAL;
        vmid = st_q.dbl ? spd_pkg::VMID_DOUBLE : spd_pkg::VMID_NORMAL;
        stop_i = nd + {3'h0, par_on};
        head = st_q.fifo[st_q.frd];

        // sample tick divider
        if (st_q.bcnt == 12'h000) begin
            st_d.bcnt = st_q.baud;
            tick = 1'b1;
        end else begin
            st_d.bcnt = st_q.bcnt - 12'h001;
        end

        // apb: one wait state, answer registered
        acc = psel & penable;
        commit = acc & st_q.pready;
        st_d.pready = acc & ~st_q.pready;
        st_d.pslverr = 1'b0;
        st_d.prdata = 32'h0000_0000;
        st_d.popok = 1'b0;
        if (acc && !st_q.pready) begin
            if (paddr == spd_pkg::ADDR_DATA) begin
                st_d.prdata[8:0] = {1'b0, head[7:0]} & spd_mask(nd);
                st_d.popok = (st_q.fcnt != 2'h0);
            end else if (paddr == spd_pkg::ADDR_STATUS) begin
                st_d.prdata[spd_pkg::ST_RXC]  = (st_q.fcnt != 2'h0);
                st_d.prdata[spd_pkg::ST_TXC]  = st_q.txc;
                st_d.prdata[spd_pkg::ST_DRE]  = ~st_q.tbuf_v;
                st_d.prdata[spd_pkg::ST_FRAME_ERROR_FLAG] = head[spd_pkg::FE_FRAME_ERROR_FLAG];
                st_d.prdata[spd_pkg::ST_OVF]  = head[spd_pkg::FE_OVF];
                st_d.prdata[spd_pkg::ST_PARITY_ERROR_FLAG] = head[spd_pkg::FE_PARITY_ERROR_FLAG];
                st_d.prdata[spd_pkg::ST_RX9]  = head[8] & (nd == spd_pkg::CHAR_MAX);
                if (st_q.fcnt == 2'h0) begin
                    st_d.prdata[spd_pkg::ST_RX9:spd_pkg::ST_FRAME_ERROR_FLAG] = 4'h0;
                end
            end else if (paddr == spd_pkg::ADDR_CTRL) begin
                st_d.prdata[spd_pkg::CT_RXEN]  = st_q.rx_en;
                st_d.prdata[spd_pkg::CT_TXEN]  = st_q.tx_en;
                st_d.prdata[spd_pkg::CT_DBL]   = st_q.dbl;
                st_d.prdata[spd_pkg::CT_CSZ +: 3]   = st_q.csize;
                st_d.prdata[spd_pkg::CT_PMODE +: 2] = st_q.pmode;
                st_d.prdata[spd_pkg::CT_STOP2] = st_q.stop2;
                st_d.prdata[spd_pkg::CT_TX9]   = st_q.tx9;
            end else if (paddr == spd_pkg::ADDR_BAUD) begin
                st_d.prdata[11:0] = st_q.baud;
            end else begin
                st_d.pslverr = 1'b1;
            end
        end

        // writes take effect at the edge that completes the transfer
        if (commit && pwrite) begin
            if (paddr == spd_pkg::ADDR_DATA) begin
                // a write into a full buffer is dropped, not queued
                if (st_q.tx_en && !st_q.tbuf_v) begin
                    st_d.tbuf = {st_q.tx9, pwdata[7:0]} & spd_mask(nd);
                    st_d.tbuf_v = 1'b1;
                end
            end else if (paddr == spd_pkg::ADDR_STATUS) begin
                clr_txc = pwdata[spd_pkg::ST_TXC];
            end else if (paddr == spd_pkg::ADDR_CTRL) begin
                st_d.rx_en = pwdata[spd_pkg::CT_RXEN];
                st_d.tx_en = pwdata[spd_pkg::CT_TXEN];
                st_d.dbl   = pwdata[spd_pkg::CT_DBL];
                st_d.csize = pwdata[spd_pkg::CT_CSZ +: 3];
                st_d.pmode = pwdata[spd_pkg::CT_PMODE +: 2];
                st_d.stop2 = pwdata[spd_pkg::CT_STOP2];
                st_d.tx9   = pwdata[spd_pkg::CT_TX9];
            end else if (paddr == spd_pkg::ADDR_BAUD) begin
                st_d.baud = pwdata[11:0];
            end
        end

        // transmitter
        frame[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(nd)) begin
                frame[1 + i] = st_q.tbuf[i];
            end
        end
        if (par_on) begin
            frame[1 + int'(nd)] = (^st_q.tbuf) ^ st_q.pmode[0];
        end
        st_d.txc = st_q.txc & ~clr_txc;
        if (st_q.tbusy) begin
            if (tick) begin
                st_d.tsmp = st_q.tsmp + 5'h01;
                if (st_d.tsmp == spb) begin
                    st_d.tsmp = 5'h00;
                    if (st_q.tbits == 4'h1) begin
                        tx_end_ev = 1'b1;
                        if (st_q.tbuf_v) begin
                            st_d.tsh = frame;
                            st_d.tbits = 4'h2 + nd + {3'h0, par_on}
                                         + {3'h0, st_q.stop2};
                            st_d.tbuf_v = 1'b0;
                            st_d.txd = 1'b0;
                        end else begin
                            st_d.tbusy = 1'b0;
                            st_d.txd = 1'b1;
                            st_d.txc = 1'b1;
                        end
                    end else begin
                        st_d.tsh = {1'b1, st_q.tsh[12:1]};
                        st_d.tbits = st_q.tbits - 4'h1;
                        st_d.txd = st_q.tsh[1];
                    end
                end
            end
        end else if (st_q.tbuf_v) begin
            st_d.tsh = frame;
            st_d.tbits = 4'h2 + nd + {3'h0, par_on} + {3'h0, st_q.stop2};
            st_d.tsmp = 5'h00;
            st_d.tbusy = 1'b1;
            st_d.tbuf_v = 1'b0;
            st_d.txd = 1'b0;
        end
        // pin released only once nothing is left to send
        st_d.tx_on = st_d.tx_en | st_d.tbusy | st_d.tbuf_v;

        // receive fifo pop
        fcnt_p = st_q.fcnt;
        frd_p = st_q.frd;
        if (commit && !pwrite && paddr == spd_pkg::ADDR_DATA && st_q.popok) begin
            fcnt_p = st_q.fcnt - 2'h1;
            frd_p = ~st_q.frd;
        end

        // receiver
        // flush on the disabling write itself, not a cycle later
        if (!st_d.rx_en) begin
            st_d.rstate = spd_pkg::RX_IDLE;
            st_d.rlast = 1'b1;
            st_d.ovf_pend = 1'b0;
            fcnt_p = 2'h0;
        end else if (tick) begin
            rs = st_q.rsmp + 5'h01;
            v = spd_maj({st_q.votes, rxd_in});
            if (rs >= vmid - 5'h01 && rs <= vmid + 5'h01) begin
                st_d.votes = {st_q.votes[0], rxd_in};
            end
            case (st_q.rstate)
                spd_pkg::RX_IDLE: begin
                    st_d.rlast = rxd_in;
                    if (st_q.rlast && !rxd_in) begin
                        st_d.rstate = spd_pkg::RX_START;
                        st_d.rsmp = 5'h01;
                    end
                end
                spd_pkg::RX_START: begin
                    st_d.rsmp = rs;
                    if (rs == vmid + 5'h01 && v) begin
                        rx_reject_ev = 1'b1;
                        st_d.rstate = spd_pkg::RX_IDLE;
                        st_d.rlast = rxd_in;
                    end else if (rs == spb) begin
                        st_d.rstate = spd_pkg::RX_BITS;
                        st_d.rsmp = 5'h00;
                        st_d.rbit = 4'h0;
                        st_d.rsh = 9'h000;
                    end
                end
                spd_pkg::RX_BITS: begin
                    st_d.rsmp = rs;
                    if (rs == vmid + 5'h01) begin
                        if (st_q.rbit < nd) begin
                            st_d.rsh[st_q.rbit] = v;
                        end else if (st_q.rbit < stop_i) begin
                            st_d.rpar = v;
                        end else begin
                            rx_push_ev = 1'b1;
                            rx_frame_error_flag_ev = ~v;
                        end
                    end
                    // normal speed rearms at the last vote, double later
                    if (st_q.rbit == stop_i &&
                        rs == (st_q.dbl ? spd_pkg::STOP_END_DBL
                                        : vmid + 5'h01)) begin
                        st_d.rstate = spd_pkg::RX_IDLE;
                        st_d.rlast = rxd_in;
                    end else if (rs == spb) begin
                        st_d.rsmp = 5'h00;
                        st_d.rbit = st_q.rbit + 4'h1;
                    end
                end
                default: begin
                    st_d.rstate = spd_pkg::RX_IDLE;
                end
            endcase
        end

        // receive fifo push; a frame that finds it full is lost
        parity_error_flag = par_on & (st_q.rpar != ((^st_q.rsh) ^ st_q.pmode[0]));
        if (rx_push_ev) begin
            if (fcnt_p == 2'h2) begin
                st_d.ovf_pend = 1'b1;
            end else begin
                st_d.fifo[frd_p ^ fcnt_p[0]] =
                    {parity_error_flag, st_q.ovf_pend, rx_frame_error_flag_ev, st_q.rsh};
                st_d.ovf_pend = 1'b0;
                fcnt_p = fcnt_p + 2'h1;
            end
        end
        st_d.fcnt = fcnt_p;
        st_d.frd = frd_p;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
            st_q.csize <= spd_pkg::CSZ_RESET;
            st_q.baud <= spd_pkg::BAUD_RESET;
            st_q.tsh <= 13'h1FFF;
            st_q.txd <= 1'b1;
            st_q.rlast <= 1'b1;
            st_q.rstate <= spd_pkg::RX_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata  = st_q.prdata;
    assign pready  = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign txd_out = st_q.txd;
    assign txd_oe  = st_q.tx_on;

    default clocking spd_cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_frame_loaded;
        st_q.tbusy && !st_q.tbuf_v && !txd_out;
    endsequence

    sequence s_noise_seen;
        st_q.rx_en && rx_reject_ev;
    endsequence

    a_txd_override: assert property (
        st_q.tx_en |-> (txd_oe && (st_q.tbusy || txd_out)))
        else $error("tx enabled but pin not driven");
    a_tx_load_idle: assert property (
        (st_q.tbuf_v && !st_q.tbusy) |=> s_frame_loaded)
        else $error("buffered character not moved to shift register");
    a_tx_chain_stop: assert property (
        (tx_end_ev && st_q.tbuf_v) |=> s_frame_loaded ##1 !txd_out)
        else $error("next frame not loaded after stop bit");
    a_txc_set: assert property (
        (tx_end_ev && !st_q.tbuf_v) |=> (st_q.txc && txd_out && !st_q.tbusy))
        else $error("transmit complete not set");
    a_tx_defer_off: assert property (
        (!st_q.tx_en && (st_q.tbusy || st_q.tbuf_v)) |-> txd_oe)
        else $error("pin released while data pending");
    a_rx_store: assert property (
        (rx_push_ev && st_q.fcnt == 2'h0) |=> (st_q.fcnt == 2'h1))
        else $error("completed frame not stored");
    a_rx_flush: assert property (
        $fell(st_q.rx_en) |-> (st_q.fcnt == 2'h0
                               && st_q.rstate == spd_pkg::RX_IDLE))
        else $error("receiver disable did not flush");
    a_start_reject: assert property (
        (s_noise_seen ##1 rxd_in) |-> (st_q.rstate == spd_pkg::RX_IDLE) [*2])
        else $error("noise start not rejected");
    a_frame_error: assert property (
        (rx_push_ev && rx_frame_error_flag_ev && st_q.fcnt == 2'h0 && !commit_pop())
        |=> st_q.fifo[st_q.frd][spd_pkg::FE_FRAME_ERROR_FLAG])
        else $error("frame error not recorded");

    function automatic logic commit_pop();
        commit_pop = psel && penable && st_q.pready && !pwrite;
    endfunction : commit_pop

endmodule : spd_top

`default_nettype wire

// >>> shared/spd_pkg.sv
/*
 * Constants for the serial port transmit and receive datapath: register
 * offsets, field positions, reset values, sample counts and rx states.
 * Assumes a 32-bit APB slave with 12 address bits.
 */
package spd_pkg;

    // register byte offsets
    localparam logic [11:0] ADDR_DATA   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CTRL   = 12'h008;
    localparam logic [11:0] ADDR_BAUD   = 12'h00C;

    // status bits
    localparam int ST_RXC  = 0;
    localparam int ST_TXC  = 1;
    localparam int ST_DRE  = 2;
    localparam int ST_FRAME_ERROR_FLAG = 3;
    localparam int ST_OVF  = 4;
    localparam int ST_PARITY_ERROR_FLAG = 5;
    localparam int ST_RX9  = 6;

    // control bits
    localparam int CT_RXEN  = 0;
    localparam int CT_TXEN  = 1;
    localparam int CT_DBL   = 2;
    localparam int CT_CSZ   = 3;
    localparam int CT_PMODE = 6;
    localparam int CT_STOP2 = 8;
    localparam int CT_TX9   = 9;

    // receive fifo entry layout
    localparam int FE_FRAME_ERROR_FLAG = 9;
    localparam int FE_OVF  = 10;
    localparam int FE_PARITY_ERROR_FLAG = 11;

    // reset values
    localparam logic [2:0]  CSZ_RESET  = 3'h3;
    localparam logic [11:0] BAUD_RESET = 12'h000;

    // character size and oversampling
    localparam logic [3:0] CHAR_MIN     = 4'h5;
    localparam logic [3:0] CHAR_MAX     = 4'h9;
    localparam logic [2:0] CSZ_MAX      = 3'h4;
    localparam logic [4:0] SPB_NORMAL   = 5'h10;
    localparam logic [4:0] SPB_DOUBLE   = 5'h08;
    localparam logic [4:0] VMID_NORMAL  = 5'h09;
    localparam logic [4:0] VMID_DOUBLE  = 5'h05;
    localparam logic [4:0] STOP_END_DBL = 5'h07;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'h1,
        RX_START = 3'h2,
        RX_BITS  = 3'h4
    } spd_rx_e;

endpackage : spd_pkg

// >>> verif/spd_remote.sv
/*
 * Remote serial station facing the serial port: sends frames on
 * rxd_in and logs every frame it sees on txd_out.
 * Assumes bit timing in whole mclk cycles, set through bit_clks.
 */
`timescale 1ns/10ps
`default_nettype none
module spd_remote (
    // clock
    input  wire logic mclk,
    // serial lines
    input  wire logic txd_out,
    output logic      rxd_in
);
    int          bit_clks = 16;
    int          rx_bits  = 8;
    logic [10:0] q[$];

    initial rxd_in = 1'b1; // idle line high

    task automatic hold(input logic v);
        @(posedge mclk);
        rxd_in <= v;
        repeat (bit_clks - 1) @(posedge mclk);
    endtask : hold

    // par: 0 none, 2 even, 3 odd; no idle gap so frames run back to back
    task automatic send(input logic [8:0] d, input int n, input int par,
                        input logic stp);
        logic p;
        p = ^(d & ((9'h1 << n) - 9'h1));
        hold(1'b0); // start bit low
        for (int i = 0; i < n; i++) hold(d[i]); // lsb first
        if (par >= 2) hold((par == 3) ? ~p : p);
        hold(stp);
        if (!stp) hold(1'b1); // a broken stop must not look like a start
    endtask : send

    task automatic glitch(input int n);
        @(posedge mclk);
        rxd_in <= 1'b0;
        repeat (n) @(posedge mclk);
        rxd_in <= 1'b1;
    endtask : glitch

    // mid-bit sampling; entry holds data, parity, then stop level
    initial begin
        logic [10:0] f;
        forever begin
            @(negedge txd_out);
            f = '0;
            repeat (bit_clks / 2) @(posedge mclk);
            for (int i = 0; i <= rx_bits; i++) begin
                repeat (bit_clks) @(posedge mclk);
                f[i] = txd_out;
            end
            q.push_back(f);
        end
    end
endmodule : spd_remote
`default_nettype wire

// >>> verif/testbench.sv
/*
 * Self-checking bench for spd_top: APB tasks drive the registers and
 * the remote station model covers the serial side.
 * Assumes BAUD left at reset, so one sample tick per clock.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        mclk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd_in;
    logic        txd_out;
    logic        txd_oe;
    logic [31:0] rd;
    logic        er;
    int          fails;
    int          checks_done;

    spd_top dut (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd_in(rxd_in), .txd_out(txd_out),
        .txd_oe(txd_oe));
    spd_remote remote (.mclk(mclk), .txd_out(txd_out), .rxd_in(rxd_in));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge mclk);
        end
        if (n == 20) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    function automatic logic [31:0] cfg(input logic [1:0] en,
        input logic dbl, input logic [2:0] csz, input logic [1:0] par,
        input logic t9);
        cfg = {30'h0, en} | (32'(dbl) << spd_pkg::CT_DBL)
            | (32'(csz) << spd_pkg::CT_CSZ) | (32'(par) << spd_pkg::CT_PMODE)
            | (32'(t9) << spd_pkg::CT_TX9);
    endfunction : cfg

    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        apb(1'b0, spd_pkg::ADDR_STATUS, 32'h0);
        while (rd[b] !== v && n < 400) begin
            n++;
            apb(1'b0, spd_pkg::ADDR_STATUS, 32'h0);
        end
        chk("status bit", {31'h0, v}, {31'h0, rd[b]});
    endtask : wait_st

    task automatic wait_tx;
        int n;
        n = 0;
        while (remote.q.size() == 0 && n < 3000) begin
            n++;
            @(posedge mclk);
        end
        chk("tx frames", 32'h1, 32'(remote.q.size()));
    endtask : wait_tx

    task automatic tx_case(input logic [31:0] c, input int bits,
                           input logic [31:0] d, input logic [31:0] e);
        apb(1'b1, spd_pkg::ADDR_CTRL, c);
        remote.rx_bits = bits;
        apb(1'b1, spd_pkg::ADDR_STATUS, 32'h2);
        apb(1'b1, spd_pkg::ADDR_DATA, d);
        wait_tx();
        chk("tx frame", e, 32'(remote.q[0]));
        remote.q.delete();
        wait_st(spd_pkg::ST_TXC, 1'b1);
    endtask : tx_case

    task automatic rx_one(input logic [31:0] fl, input logic [31:0] e);
        wait_st(spd_pkg::ST_RXC, 1'b1);
        chk("rx flags", fl, rd & 32'h78);
        apb(1'b0, spd_pkg::ADDR_DATA, 32'h0);
        chk("rx data", e, rd);
    endtask : rx_one

    task automatic rx_case(input logic [2:0] csz, input logic [1:0] cp,
        input logic [8:0] d, input int n, input int sp, input logic stp,
        input logic [31:0] fl, input logic [31:0] e);
        apb(1'b1, spd_pkg::ADDR_CTRL, cfg(2'h1, 1'b0, csz, cp, 1'b0));
        remote.send(d, n, sp, stp);
        rx_one(fl, e);
    endtask : rx_case

    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        report_and_stop();
    end

    initial begin
        fails = 0;
        checks_done = 0;
        reset = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk("txd_oe", 32'h0, {31'h0, txd_oe});
        apb(1'b0, spd_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h4, rd & 32'h5);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, spd_pkg::ADDR_CTRL, cfg(2'h3, 1'b0, 3'h3, 2'h0, 1'b0));
        apb(1'b1, spd_pkg::ADDR_DATA, 32'hA5);
        wait_st(spd_pkg::ST_DRE, 1'b1);
        apb(1'b1, spd_pkg::ADDR_DATA, 32'h3C);
        chk("txd_oe", 32'h1, {31'h0, txd_oe});
        wait_tx();
        chk("tx frame", 32'h1A5, 32'(remote.q.pop_front()));
        wait_tx();
        chk("tx frame", 32'h13C, 32'(remote.q.pop_front()));
        wait_st(spd_pkg::ST_TXC, 1'b1);
        apb(1'b1, spd_pkg::ADDR_STATUS, 32'h2);
        wait_st(spd_pkg::ST_TXC, 1'b0);
        tx_case(cfg(2'h3, 1'b0, 3'h0, 2'h2, 1'b0), 6, 32'hFF, 32'h7F);
        tx_case(cfg(2'h3, 1'b0, 3'h0, 2'h3, 1'b0), 6, 32'h3, 32'h63);
        tx_case(cfg(2'h3, 1'b0, 3'h4, 2'h0, 1'b1), 9, 32'h5A, 32'h35A);
        apb(1'b1, spd_pkg::ADDR_CTRL, cfg(2'h3, 1'b0, 3'h3, 2'h0, 1'b0));
        remote.rx_bits = 8;
        apb(1'b1, spd_pkg::ADDR_DATA, 32'h81);
        apb(1'b1, spd_pkg::ADDR_CTRL, cfg(2'h1, 1'b0, 3'h3, 2'h0, 1'b0));
        chk("txd_oe", 32'h1, {31'h0, txd_oe});
        wait_tx();
        chk("tx frame", 32'h181, 32'(remote.q.pop_front()));
        repeat (40) @(posedge mclk);
        chk("txd_oe", 32'h0, {31'h0, txd_oe});
        rx_case(3'h3, 2'h0, 9'h5A, 8, 0, 1'b1, 32'h0, 32'h5A);
        rx_case(3'h3, 2'h2, 9'hFF, 8, 2, 1'b1, 32'h0, 32'hFF);
        rx_case(3'h0, 2'h0, 9'h15, 5, 0, 1'b1, 32'h0, 32'h15);
        rx_case(3'h3, 2'h2, 9'h33, 8, 3, 1'b1, 32'h20, 32'h33);
        rx_case(3'h3, 2'h3, 9'h0C, 8, 3, 1'b1, 32'h0, 32'h0C);
        rx_case(3'h3, 2'h0, 9'h47, 8, 0, 1'b0, 32'h8, 32'h47);
        rx_case(3'h4, 2'h0, 9'h1A5, 9, 0, 1'b1, 32'h40, 32'hA5);
        apb(1'b1, spd_pkg::ADDR_CTRL, cfg(2'h1, 1'b0, 3'h3, 2'h0, 1'b0));
        remote.send(9'h11, 8, 0, 1'b1);
        remote.send(9'h22, 8, 0, 1'b1);
        remote.send(9'h33, 8, 0, 1'b1);
        rx_one(32'h0, 32'h11);
        rx_one(32'h0, 32'h22);
        remote.send(9'h44, 8, 0, 1'b1);
        rx_one(32'h10, 32'h44);
        remote.send(9'h55, 8, 0, 1'b1);
        remote.send(9'h56, 8, 0, 1'b1);
        wait_st(spd_pkg::ST_RXC, 1'b1);
        repeat (2) begin
            chk("rx pending", 32'h1, rd & 32'h1);
            apb(1'b0, spd_pkg::ADDR_DATA, 32'h0);
            apb(1'b0, spd_pkg::ADDR_STATUS, 32'h0);
        end
        chk("rx flushed", 32'h0, rd & 32'h1);
        remote.glitch(7);
        repeat (30) @(posedge mclk);
        apb(1'b0, spd_pkg::ADDR_STATUS, 32'h0);
        chk("rx after noise", 32'h0, {31'h0, rd[0]});
        remote.send(9'h77, 8, 0, 1'b1);
        wait_st(spd_pkg::ST_RXC, 1'b1);
        apb(1'b1, spd_pkg::ADDR_CTRL, cfg(2'h0, 1'b0, 3'h3, 2'h0, 1'b0));
        wait_st(spd_pkg::ST_RXC, 1'b0);
        remote.send(9'h66, 8, 0, 1'b1);
        wait_st(spd_pkg::ST_RXC, 1'b0);
        remote.bit_clks = 8;
        apb(1'b1, spd_pkg::ADDR_CTRL, cfg(2'h1, 1'b1, 3'h3, 2'h0, 1'b0));
        remote.glitch(3);
        repeat (20) @(posedge mclk);
        apb(1'b0, spd_pkg::ADDR_STATUS, 32'h0);
        chk("rx after noise", 32'h0, {31'h0, rd[0]});
        remote.send(9'h96, 8, 0, 1'b1);
        rx_one(32'h0, 32'h96);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
